/* File: hw/ctu_top.sv */
// What this block does
// - Apart from the discharge, trim, range and interrupt outputs, the unit works only while the unit enable bit is set.
// - With idle stop set, all but the discharge, trim, range and interrupt outputs halt while the device is idle.
// - Time generation enable turns edge delay generation on or off.
// - Hardware edge enable picks hardware sources; otherwise software writes status bits.
// - Edge sequencing blocks a second edge until the first edge occurred.
// - Discharge bit grounds the current source output.
// - Conversion trigger bit lets the unit start an ADC conversion.
// - Each edge has a sampling mode bit: edge when set, level when clear.
// - Each edge has a polarity bit: positive when set, negative when clear.
// - Four-bit source select: timer, compare module, two pins; others reserved.
// - Hardware sets status bits on edges; software may write them directly.
// - Six-bit trim field steps current by two percent, signed.
// - Equal status bits with time generation on keep source on, shunted.
// - Channel zero switch closes while the discharge bit is one.
// - Unimplemented register bits read zero and ignore writes.
`timescale 1ns/1ps
module ctu_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [2:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [15:0] regRdata,
  // Device state
  input  wire logic        deviceIdle,
  // Edge sources
  input  wire logic        timerOneEvent,
  input  wire logic        compareModuleOne,
  input  wire logic        edgePinOne,
  input  wire logic        edgePinTwo,
  // Analog controls
  output logic             sourceEnable,
  output logic             sourceShunt,
  output logic             sourceGround,
  output logic             adcChannelZeroSwitch,
  output logic [5:0]       currentTrim,
  output logic [1:0]       currentRange,
  output logic             adcStartTrigger,
  // Interrupt
  output logic             irq
);
  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [15:0] ctrlOne;
  logic [15:0] ctrlTwo;
  logic [15:0] curCtrl;
  logic [15:0] next_ctrlOne;
  logic [15:0] next_ctrlTwo;
  logic [15:0] next_curCtrl;
  logic [ctu_pkg::IRQ_WIDTH-1:0] irqStatus;
  logic [ctu_pkg::IRQ_WIDTH-1:0] irqEnable;
  logic [ctu_pkg::IRQ_WIDTH-1:0] next_irqStatus;
  logic [ctu_pkg::IRQ_WIDTH-1:0] next_irqEnable;
  logic [15:0] next_regRdata;
  logic        statOne;
  logic        statTwo;
  logic        next_statOne;
  logic        next_statTwo;
  logic        next_adcStartTrigger;

  //////////////////////////////////////////////////////////////////////////////
  // Source synchronisers and selection
  logic [3:0] rawSrc;
  logic [3:0] syncSrc;
  logic       selOne;
  logic       selTwo;
  logic       hitOne;
  logic       hitTwo;
  logic       srcOkOne;
  logic       srcOkTwo;

  assign rawSrc = {edgePinTwo, edgePinOne, compareModuleOne, timerOneEvent};

  // Pins and other-domain events get two flops before use
  ctu_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk    (clk),
    .rstn   (rstn),
    .async  (rawSrc),
    .synced (syncSrc)
  );

  function automatic logic pickSource(input logic [3:0] sel, input logic [3:0] src);
    logic r;
    r = 1'b0;
    case (sel)
      ctu_pkg::SRC_TIMER:   r = src[0];
      ctu_pkg::SRC_COMPARE: r = src[1];
      ctu_pkg::SRC_PIN_ONE: r = src[2];
      ctu_pkg::SRC_PIN_TWO: r = src[3];
      default:              r = 1'b0;   // Reserved codes never fire
    endcase
    return r;
  endfunction

  assign selOne = pickSource(ctrlTwo[ctu_pkg::FIRST_SEL_LSB +: 4], syncSrc);
  assign selTwo = pickSource(ctrlTwo[ctu_pkg::SECOND_SEL_LSB +: 4], syncSrc);
  // Reserved codes select nothing, even where level sensing would take the idle low
  assign srcOkOne = ctrlTwo[ctu_pkg::FIRST_SEL_LSB + 2 +: 2] == 2'b00;
  assign srcOkTwo = ctrlTwo[ctu_pkg::SECOND_SEL_LSB + 2 +: 2] == 2'b00;

  ctu_edge_detect u_edgeOne (
    .clk      (clk),
    .rstn     (rstn),
    .edgeMode (ctrlTwo[ctu_pkg::FIRST_MODE_BIT]),
    .polarity (ctrlTwo[ctu_pkg::FIRST_POL_BIT]),
    .level    (selOne),
    .hit      (hitOne)
  );

  ctu_edge_detect u_edgeTwo (
    .clk      (clk),
    .rstn     (rstn),
    .edgeMode (ctrlTwo[ctu_pkg::SECOND_MODE_BIT]),
    .polarity (ctrlTwo[ctu_pkg::SECOND_POL_BIT]),
    .level    (selTwo),
    .hit      (hitTwo)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Operating state
  logic running;
  logic hwEdges;
  logic acceptOne;
  logic acceptTwo;
  logic wrOne;
  logic wrTwo;
  logic wrCur;

  assign running = ctrlOne[ctu_pkg::UNIT_ENABLE_BIT]
                 & ~(ctrlOne[ctu_pkg::IDLE_STOP_BIT] & deviceIdle);
  assign hwEdges = running & ctrlOne[ctu_pkg::HW_EDGE_BIT];
  assign acceptOne = hwEdges & hitOne & srcOkOne;
  // Second edge waits for the first when sequencing is on
  assign acceptTwo = hwEdges & hitTwo & srcOkTwo
                   & (~ctrlOne[ctu_pkg::EDGE_SEQ_BIT] | statOne | acceptOne);
  assign wrOne = regWrite & (regAddr == ctu_pkg::ADDR_CTRL_ONE);
  assign wrTwo = regWrite & (regAddr == ctu_pkg::ADDR_CTRL_TWO);
  assign wrCur = regWrite & (regAddr == ctu_pkg::ADDR_CUR_CTRL);

  //////////////////////////////////////////////////////////////////////////////
  // Register file and edge status
  always_comb begin
    next_ctrlOne   = ctrlOne;
    next_ctrlTwo   = ctrlTwo;
    next_curCtrl   = curCtrl;
    next_irqEnable = irqEnable;
    next_statOne   = statOne;
    next_statTwo   = statTwo;
    if (wrOne) begin
      next_ctrlOne = regWdata & ctu_pkg::CTRL_ONE_MASK;
    end
    if (wrTwo) begin
      next_ctrlTwo = regWdata & ctu_pkg::CTRL_TWO_MASK;
      next_statOne = regWdata[ctu_pkg::FIRST_STAT_BIT];
      next_statTwo = regWdata[ctu_pkg::SECOND_STAT_BIT];
    end
    if (wrCur) begin
      next_curCtrl = regWdata & ctu_pkg::CUR_CTRL_MASK;
    end
    if (regWrite && regAddr == ctu_pkg::ADDR_IRQ_ENABLE) begin
      next_irqEnable = regWdata[ctu_pkg::IRQ_WIDTH-1:0];
    end
    // Hardware edges win over a same-cycle software write
    if (acceptOne) begin
      next_statOne = 1'b1;
    end
    if (acceptTwo) begin
      next_statTwo = 1'b1;
    end
  end

  // Interrupt status: set wins over clear
  always_comb begin
    next_irqStatus = irqStatus;
    if (regWrite && regAddr == ctu_pkg::ADDR_IRQ_CLEAR) begin
      next_irqStatus = irqStatus & ~regWdata[ctu_pkg::IRQ_WIDTH-1:0];
    end
    next_irqStatus = next_irqStatus | {acceptTwo, acceptOne};
  end

  // Read data one cycle after the strobe, zero otherwise
  always_comb begin
    next_regRdata = 16'h0000;
    if (regRead) begin
      case (regAddr)
        ctu_pkg::ADDR_CTRL_ONE: next_regRdata = ctrlOne;
        ctu_pkg::ADDR_CTRL_TWO: begin
          next_regRdata = ctrlTwo;
          next_regRdata[ctu_pkg::FIRST_STAT_BIT]  = statOne;
          next_regRdata[ctu_pkg::SECOND_STAT_BIT] = statTwo;
        end
        ctu_pkg::ADDR_CUR_CTRL:   next_regRdata = curCtrl;
        ctu_pkg::ADDR_IRQ_STATUS: next_regRdata = {14'h0000, irqStatus};
        ctu_pkg::ADDR_IRQ_ENABLE: next_regRdata = {14'h0000, irqEnable};
        default:                  next_regRdata = 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Analog controls
  logic timeGen;
  logic oneSet;
  logic bothDone;
  logic prevBothDone;
  logic next_prevBothDone;

  assign timeGen  = running & ctrlOne[ctu_pkg::TIME_GEN_BIT];
  assign oneSet   = statOne ^ statTwo;
  assign bothDone = statOne & statTwo;

  always_comb begin
    next_prevBothDone    = bothDone;
    // One-cycle start pulse when the timed interval closes
    next_adcStartTrigger = running & ctrlOne[ctu_pkg::CONV_TRIG_BIT]
                         & bothDone & ~prevBothDone;
  end

  always_comb begin
    // Current flows between edges; with time generation it stays on, shunted
    sourceEnable = running & (oneSet | timeGen);
    sourceShunt  = timeGen & ~oneSet;
    sourceGround = ctrlOne[ctu_pkg::DISCHARGE_BIT];
    adcChannelZeroSwitch = ctrlOne[ctu_pkg::DISCHARGE_BIT];
    currentTrim  = curCtrl[ctu_pkg::TRIM_LSB +: 6];
    currentRange = curCtrl[ctu_pkg::RANGE_LSB +: 2];
    irq          = |(irqStatus & irqEnable);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrlOne         <= ctu_pkg::RESET_VALUE;
      ctrlTwo         <= ctu_pkg::RESET_VALUE;
      curCtrl         <= ctu_pkg::RESET_VALUE;
      irqStatus       <= '0;
      irqEnable       <= '0;
      statOne         <= 1'b0;
      statTwo         <= 1'b0;
      regRdata        <= 16'h0000;
      prevBothDone    <= 1'b0;
      adcStartTrigger <= 1'b0;
    end else begin
      ctrlOne         <= next_ctrlOne;
      ctrlTwo         <= next_ctrlTwo;
      curCtrl         <= next_curCtrl;
      irqStatus       <= next_irqStatus;
      irqEnable       <= next_irqEnable;
      statOne         <= next_statOne;
      statTwo         <= next_statTwo;
      regRdata        <= next_regRdata;
      prevBothDone    <= next_prevBothDone;
      adcStartTrigger <= next_adcStartTrigger;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence firstPending;
    ctrlOne[ctu_pkg::EDGE_SEQ_BIT] && !statOne && !acceptOne && !wrTwo;
  endsequence

  sequence intervalEnds;
    running && ctrlOne[ctu_pkg::CONV_TRIG_BIT] && bothDone && !prevBothDone;
  endsequence

  disabled_stops_a: assert property (@(posedge clk) disable iff (!rstn)
    !ctrlOne[ctu_pkg::UNIT_ENABLE_BIT] && !wrTwo |=> $stable(statOne) && $stable(statTwo))
    else $error("Disabled unit changed edge status");

  idle_halts_a: assert property (@(posedge clk) disable iff (!rstn)
    ctrlOne[ctu_pkg::IDLE_STOP_BIT] && deviceIdle |-> !sourceEnable && !acceptOne)
    else $error("Unit kept running in idle");

  sw_edges_a: assert property (@(posedge clk) disable iff (!rstn)
    !ctrlOne[ctu_pkg::HW_EDGE_BIT] && !statOne && !wrTwo |=> !statOne)
    else $error("Edge one set without hardware enable");

  seq_order_a: assert property (@(posedge clk) disable iff (!rstn)
    firstPending |=> !$rose(statTwo))
    else $error("Second edge accepted before first");

  discharge_path_a: assert property (@(posedge clk) disable iff (!rstn)
    wrOne |=> sourceGround == $past(regWdata[ctu_pkg::DISCHARGE_BIT]) && adcChannelZeroSwitch == sourceGround)
    else $error("Discharge outputs do not follow control");

  adc_trigger_a: assert property (@(posedge clk) disable iff (!rstn)
    intervalEnds |=> adcStartTrigger ##1 !adcStartTrigger)
    else $error("Conversion trigger not a single pulse");

  status_write_a: assert property (@(posedge clk) disable iff (!rstn)
    wrTwo && !hwEdges |=> statOne == $past(regWdata[ctu_pkg::FIRST_STAT_BIT]))
    else $error("Software edge status write lost");

  reserved_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    regRead && regAddr == ctu_pkg::ADDR_CUR_CTRL |=> regRdata[7:0] == 8'h00)
    else $error("Reserved bits read nonzero");

  current_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    running && (statOne != statTwo) |-> sourceEnable && !sourceShunt)
    else $error("Source off between edges");

  reserved_src_a: assert property (@(posedge clk) disable iff (!rstn)
    !srcOkOne && !statOne && !wrTwo |=> !statOne)
    else $error("Reserved source set edge one");

  shunt_equal_a: assert property (@(posedge clk) disable iff (!rstn)
    timeGen && (statOne == statTwo) |-> sourceEnable && sourceShunt)
    else $error("Source not kept on and shunted");

  time_gen_off_a: assert property (@(posedge clk) disable iff (!rstn)
    !timeGen && (statOne == statTwo) |-> !sourceEnable && !sourceShunt)
    else $error("Source on without time generation");

  switch_follows_a: assert property (@(posedge clk) disable iff (!rstn)
    wrOne |=> adcChannelZeroSwitch == $past(regWdata[ctu_pkg::DISCHARGE_BIT]))
    else $error("Channel zero switch does not follow discharge bit");

  trim_field_a: assert property (@(posedge clk) disable iff (!rstn)
    wrCur |=> currentTrim == $past(regWdata[ctu_pkg::TRIM_LSB +: 6]))
    else $error("Trim output does not follow register");

  range_field_a: assert property (@(posedge clk) disable iff (!rstn)
    wrCur |=> currentRange == $past(regWdata[ctu_pkg::RANGE_LSB +: 2]))
    else $error("Range output does not follow register");

  hw_edge_sets_a: assert property (@(posedge clk) disable iff (!rstn)
    acceptOne |=> statOne)
    else $error("Accepted edge one not recorded");

  edge_mode_a: assert property (@(posedge clk) disable iff (!rstn)
    ctrlTwo[ctu_pkg::FIRST_MODE_BIT] && $stable(selOne) && !statOne && !wrTwo |=> !statOne)
    else $error("Edge mode fired on a steady source");

  polarity_a: assert property (@(posedge clk) disable iff (!rstn)
    ctrlTwo[ctu_pkg::FIRST_MODE_BIT] && ctrlTwo[ctu_pkg::FIRST_POL_BIT] && $fell(selOne) && !statOne && !wrTwo
      |=> !statOne)
    else $error("Positive edge setting fired on a fall");
endmodule

/* File: hw/ctu_pkg.sv */
package ctu_pkg;
  // Register offsets (word index on the plain port)
  localparam logic [2:0] ADDR_CTRL_ONE   = 3'h0;
  localparam logic [2:0] ADDR_CTRL_TWO   = 3'h1;
  localparam logic [2:0] ADDR_CUR_CTRL   = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h3;
  localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h4;
  localparam logic [2:0] ADDR_IRQ_CLEAR  = 3'h5;
  // Control one fields
  localparam int UNIT_ENABLE_BIT  = 15;
  localparam int IDLE_STOP_BIT    = 13;
  localparam int TIME_GEN_BIT     = 12;
  localparam int HW_EDGE_BIT      = 11;
  localparam int EDGE_SEQ_BIT     = 10;
  localparam int DISCHARGE_BIT    = 9;
  localparam int CONV_TRIG_BIT    = 8;
  localparam logic [15:0] CTRL_ONE_MASK = 16'hBF00;
  // Control two fields
  localparam int FIRST_MODE_BIT   = 15;
  localparam int FIRST_POL_BIT    = 14;
  localparam int FIRST_SEL_LSB    = 10;
  localparam int SECOND_STAT_BIT  = 9;
  localparam int FIRST_STAT_BIT   = 8;
  localparam int SECOND_MODE_BIT  = 7;
  localparam int SECOND_POL_BIT   = 6;
  localparam int SECOND_SEL_LSB   = 2;
  localparam logic [15:0] CTRL_TWO_MASK = 16'hFFFC;
  // Current control fields
  localparam int TRIM_LSB         = 10;
  localparam int RANGE_LSB        = 8;
  localparam logic [15:0] CUR_CTRL_MASK = 16'hFF00;
  // Interrupt bits: first edge, second edge
  localparam int IRQ_WIDTH        = 2;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  // Source select codes
  localparam logic [3:0] SRC_TIMER   = 4'h0;
  localparam logic [3:0] SRC_COMPARE = 4'h1;
  localparam logic [3:0] SRC_PIN_ONE = 4'h2;
  localparam logic [3:0] SRC_PIN_TWO = 4'h3;
endpackage

/* File: hw/ctu_sync.sv */
`timescale 1ns/1ps
module ctu_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Data
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stageOne;
  logic [WIDTH-1:0] next_stageOne;
  logic [WIDTH-1:0] next_synced;

  always_comb begin
    next_stageOne = async;
    next_synced   = stageOne;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      stageOne <= '0;
      synced   <= '0;
    end else begin
      stageOne <= next_stageOne;
      synced   <= next_synced;
    end
  end
endmodule

/* File: hw/ctu_edge_detect.sv */
`timescale 1ns/1ps
module ctu_edge_detect (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Configuration
  input  wire logic edgeMode,
  input  wire logic polarity,
  // Source
  input  wire logic level,
  output logic      hit
);
  logic prevLevel;
  logic next_prevLevel;
  logic active;

  always_comb begin
    next_prevLevel = level;
    active         = polarity ? level : ~level;
    // Edge mode: transition toward the active level; level mode: active level
    if (edgeMode) begin
      hit = polarity ? (level & ~prevLevel) : (~level & prevLevel);
    end else begin
      hit = active;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prevLevel <= 1'b0;
    end else begin
      prevLevel <= next_prevLevel;
    end
  end
endmodule

/* File: test/ctu_source_model.sv */
`timescale 1ns/1ps
module ctu_source_model (
  // Clock
  input  wire logic       clk,
  // Requested levels: timer, compare, pin one, pin two
  input  wire logic [3:0] srcLevel,
  // Source outputs
  output logic      [3:0] srcOut
);
  initial srcOut = 4'h0;
  // Skewed off the edge: the far side is not synchronous to this clock
  always @(posedge clk) begin
    srcOut <= #3 srcLevel;
  end
endmodule

/* File: test/edge_timed_current_source_ctrl_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin nTests++; if ((got) !== (ex)) begin errTotal++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module edge_timed_current_source_ctrl_bench;
  logic        clk        = 1'b0;
  logic        rstn       = 1'b0;
  logic [2:0]  regAddr    = 3'h0;
  logic [15:0] regWdata   = 16'h0000;
  logic        regWrite   = 1'b0;
  logic        regRead    = 1'b0;
  logic        deviceIdle = 1'b0;
  logic [3:0]  srcLevel   = 4'h0;
  logic [15:0] regRdata;
  logic [3:0]  srcOut;
  logic        sourceEnable;
  logic        sourceShunt;
  logic        sourceGround;
  logic        adcChannelZeroSwitch;
  logic [5:0]  currentTrim;
  logic [1:0]  currentRange;
  logic        adcStartTrigger;
  logic        irq;
  int          errTotal   = 0;
  int          nTests     = 0;
  int          trigCount  = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (adcStartTrigger === 1'b1) trigCount++;

  ctu_source_model PARTNER (.clk(clk), .srcLevel(srcLevel), .srcOut(srcOut));

  ctu_top DUT (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .deviceIdle(deviceIdle),
    .timerOneEvent(srcOut[0]), .compareModuleOne(srcOut[1]), .edgePinOne(srcOut[2]),
    .edgePinTwo(srcOut[3]), .sourceEnable(sourceEnable), .sourceShunt(sourceShunt),
    .sourceGround(sourceGround), .adcChannelZeroSwitch(adcChannelZeroSwitch),
    .currentTrim(currentTrim), .currentRange(currentRange),
    .adcStartTrigger(adcStartTrigger), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input logic [2:0] a, input logic [15:0] ex);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    `CHK($sformatf("reg%0d", a), ex, regRdata);
  endtask

  // Sync plus detect takes three cycles; six leaves margin
  task automatic src(input logic [3:0] v);
    @(posedge clk);
    srcLevel <= v;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic stopTest();
    $display("Comparisons %0d mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    errTotal++;
    stopTest();
  end

  initial begin
    logic [15:0] c2;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 5; a++) rdchk(a[2:0], 16'h0000);
    `CHK("irq", 1'b0, irq);
    // Full writes land only on implemented bits
    wr(ctu_pkg::ADDR_CTRL_ONE, 16'hFFFF);
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'hFFFF);
    wr(ctu_pkg::ADDR_CUR_CTRL, 16'hFFFF);
    rdchk(ctu_pkg::ADDR_CTRL_ONE, 16'hBF00);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'hFFFC);
    rdchk(ctu_pkg::ADDR_CUR_CTRL, 16'hFF00);
    `CHK("sourceGround", 1'b1, sourceGround);
    `CHK("adcSwitch", 1'b1, adcChannelZeroSwitch);
    `CHK("sourceShunt", 1'b1, sourceShunt);
    `CHK("trigCount", 1, trigCount);
    wr(3'h6, 16'hFFFF);
    rdchk(3'h6, 16'h0000);
    wr(ctu_pkg::ADDR_CUR_CTRL, 16'h8900);
    `CHK("currentTrim", 6'h22, currentTrim);
    `CHK("currentRange", 2'h1, currentRange);
    wr(ctu_pkg::ADDR_CUR_CTRL, 16'h0600);
    `CHK("currentTrim", 6'h01, currentTrim);
    `CHK("currentRange", 2'h2, currentRange);
    wr(ctu_pkg::ADDR_CTRL_ONE, 16'h0000);
    `CHK("sourceGround", 1'b0, sourceGround);
    `CHK("adcSwitch", 1'b0, adcChannelZeroSwitch);
    // Software-driven edges
    wr(ctu_pkg::ADDR_CTRL_ONE, 16'h8000);
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'h0100);
    `CHK("sourceEnable", 1'b1, sourceEnable);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'h0100);
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'h0300);
    `CHK("sourceEnable", 1'b0, sourceEnable);
    `CHK("sourceShunt", 1'b0, sourceShunt);
    wr(ctu_pkg::ADDR_CTRL_ONE, 16'h9000);
    `CHK("sourceEnable", 1'b1, sourceEnable);
    `CHK("sourceShunt", 1'b1, sourceShunt);
    // Every implemented source select code, positive edge; edge 2 parked on a reserved code
    // Park the sources and clear old events before hardware edges go on
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'hC010);
    wr(ctu_pkg::ADDR_IRQ_CLEAR, 16'h0003);
    wr(ctu_pkg::ADDR_IRQ_ENABLE, 16'h0003);
    `CHK("irq", 1'b0, irq);
    wr(ctu_pkg::ADDR_CTRL_ONE, 16'h8800);
    for (int s = 0; s < 4; s++) begin
      c2 = 16'hC010 | (16'(s) << ctu_pkg::FIRST_SEL_LSB);
      wr(ctu_pkg::ADDR_CTRL_TWO, c2);
      src(4'(1 << s));
      rdchk(ctu_pkg::ADDR_CTRL_TWO, c2 | 16'h0100);
      `CHK("irq", 1'b1, irq);
      src(4'h0);
      wr(ctu_pkg::ADDR_IRQ_CLEAR, 16'h0003);
      `CHK("irq", 1'b0, irq);
    end
    // Negative polarity ignores the rise, takes the fall
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'h8010);
    src(4'h1);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'h8010);
    src(4'h0);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'h8110);
    // Level mode re-sets while the source is held; edge mode does not
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'h4010);
    src(4'h1);
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'h4010);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'h4110);
    // Old level setting still wins the switching write; the second one lands
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'hC010);
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'hC010);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'hC010);
    src(4'h0);
    // Sequencing with conversion trigger
    trigCount = 0;
    wr(ctu_pkg::ADDR_CTRL_ONE, 16'h8D00);
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'hC0C4);
    src(4'h2);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'hC0C4);
    src(4'h0);
    src(4'h1);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'hC1C4);
    src(4'h0);
    src(4'h2);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'hC3C4);
    `CHK("trigCount", 1, trigCount);
    src(4'h0);
    // No sequencing, no trigger
    wr(ctu_pkg::ADDR_CTRL_ONE, 16'h8800);
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'hC0C4);
    src(4'h2);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'hC2C4);
    src(4'h1);
    `CHK("trigCount", 1, trigCount);
    src(4'h0);
    // Unit disabled
    wr(ctu_pkg::ADDR_CTRL_ONE, 16'h0800);
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'hC0C4);
    src(4'h1);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'hC0C4);
    src(4'h0);
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'h0100);
    `CHK("sourceEnable", 1'b0, sourceEnable);
    // Idle stop halts, idle without it keeps running
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'hC0C4);
    wr(ctu_pkg::ADDR_CTRL_ONE, 16'hA800);
    @(posedge clk);
    deviceIdle <= 1'b1;
    src(4'h1);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'hC0C4);
    src(4'h0);
    wr(ctu_pkg::ADDR_CTRL_ONE, 16'h8800);
    src(4'h1);
    rdchk(ctu_pkg::ADDR_CTRL_TWO, 16'hC1C4);
    src(4'h0);
    @(posedge clk);
    deviceIdle <= 1'b0;
    // Interrupt status, mask and clear
    wr(ctu_pkg::ADDR_IRQ_CLEAR, 16'h0003);
    wr(ctu_pkg::ADDR_CTRL_TWO, 16'hC0C4);
    src(4'h1);
    rdchk(ctu_pkg::ADDR_IRQ_STATUS, 16'h0001);
    `CHK("irq", 1'b1, irq);
    wr(ctu_pkg::ADDR_IRQ_ENABLE, 16'h0002);
    `CHK("irq", 1'b0, irq);
    wr(ctu_pkg::ADDR_IRQ_ENABLE, 16'h0001);
    wr(ctu_pkg::ADDR_IRQ_CLEAR, 16'h0001);
    `CHK("irq", 1'b0, irq);
    rdchk(ctu_pkg::ADDR_IRQ_STATUS, 16'h0000);
    stopTest();
  end
endmodule
